// File: rtl/bevs_pkg.sv
// Shared constants and carrier types of the bulk erase verify sequencer.
// Assumes a 200 MHz ref_clk and a byte-wide flash with a command register.
package bevs_pkg;
    localparam int ADDR_W = 17;
    localparam int CLK_PERIOD_NS = 5;
    // Times in their own units, and the derived cycle counts.
    localparam int T_ERASE_MS = 10;
    localparam int T_PROG_US = 10;
    localparam int T_SETTLE_US = 6;
    localparam int T_VPP_NS = 100;
    localparam int ERASE_CYC = T_ERASE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROG_CYC = T_PROG_US * 1000 / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (T_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VPP_CYC = (T_VPP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_LOW_CYC = 10;
    localparam int READ_CYC = 14;
    localparam int MAX_ERASE_PULSES = 1000;
    localparam int MAX_PROG_PULSES = 25;
    // Command codes and data patterns.
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_VFY = 8'ha0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_VFY = 8'hc0;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] DATA_ERASED = 8'hff;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // One bus cycle request: write or read, address and write data.
    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } bevs_req_t;

    // Flash pin bundle driven by the controller.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
    } bevs_pins_t;
endpackage

// File: rtl/bevs_bus_cycle.sv
// Single flash bus cycle engine: one write or one read per request.
// Assumes the requester waits for done before issuing the next request.
`timescale 1ns/100ps
module bevs_bus_cycle
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire bevs_pkg::bevs_req_t req,
    input wire logic [7:0] dq_in,
    output bevs_pkg::bevs_pins_t pins,
    output logic done,
    output logic [7:0] rdata
);
    import bevs_pkg::*;

    typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_RELEASE, B_END} bevs_bus_st_t;

    bevs_bus_st_t state_r;
    logic [7:0] dq_meta_r;
    logic [7:0] dq_sync_r;
    logic [4:0] cnt_r;
    logic wr_r;

    // Data pins come from another domain, so two flops before use.
    always_ff @(posedge ref_clk)
    begin
        dq_meta_r <= dq_in;
        dq_sync_r <= dq_meta_r;
    end

    // Chip select falls first, the strobe one cycle later, so the strobe is
    // always the later falling edge and the address is stable before it.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_r <= B_IDLE;
            pins <= '{addr: '0, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
            done <= 1'b0;
            rdata <= 8'h00;
            cnt_r <= 5'h00;
            wr_r <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state_r)
                B_IDLE:
                    if (req_valid)
                    begin
                        wr_r <= req.wr;
                        pins.addr <= req.addr;
                        pins.dq_out <= req.data;
                        pins.dq_oe <= req.wr;
                        pins.ce_n <= 1'b0;
                        state_r <= B_SETUP;
                    end
                B_SETUP:
                begin
                    pins.we_n <= !wr_r;
                    pins.oe_n <= wr_r;
                    cnt_r <= wr_r ? 5'(WE_LOW_CYC - 1) : 5'(READ_CYC + 1);
                    state_r <= B_STROBE;
                end
                B_STROBE:
                    if (cnt_r == 5'h00)
                    begin
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        if (!wr_r)
                        begin
                            rdata <= dq_sync_r;
                        end
                        state_r <= B_RELEASE;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 5'h01;
                    end
                B_RELEASE:
                begin
                    pins.ce_n <= 1'b1; // Data held past the strobe's rising edge.
                    state_r <= B_END;
                end
                B_END:
                begin
                    pins.dq_oe <= 1'b0;
                    done <= 1'b1;
                    state_r <= B_IDLE;
                end
            endcase
        end
    end
endmodule // bevs_bus_cycle

// File: rtl/bevs_erase_host.sv
// Host-side bulk erase sequencer for a byte-wide flash with a command register.
// Assumes the flash pins are wired straight to the ports and that
// program_voltage_pin switches the high programming supply.
`timescale 1ns/100ps
module bevs_erase_host
#(
    parameter int ERASE_CYCLES = bevs_pkg::ERASE_CYC,
    parameter logic [bevs_pkg::ADDR_W-1:0] LAST_ADDR = 17'h1ffff
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [7:0] flash_dq_in,
    output bevs_pkg::bevs_pins_t flash_pins,
    output logic program_voltage_pin,
    output logic busy,
    output logic finished,
    output logic erase_ok,
    output logic erase_fail,
    output logic erase_skipped,
    output logic [9:0] erase_pulse_counter,
    output logic [bevs_pkg::ADDR_W-1:0] fail_addr
);
    import bevs_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE, S_RAMP, S_RD_CMD, S_RD_BYTE,
        S_PG_SETUP, S_PG_WRITE, S_PG_PULSE, S_PG_VCMD, S_PG_SETTLE, S_PG_READ,
        S_ER_SETUP, S_ER_WRITE, S_ER_PULSE, S_EV_CMD, S_EV_SETTLE, S_EV_READ,
        S_EXIT, S_VPP_DN
    } bevs_state_t;

    bevs_state_t state_r;
    bevs_state_t state_nxt;
    logic [23:0] wait_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [4:0] pcnt_r;
    logic [4:0] pcnt_nxt;
    logic [9:0] ecnt_nxt;
    logic pend_r;
    logic req_valid_r;
    bevs_req_t req_r;
    logic bus_done;
    logic [7:0] bus_rdata;
    logic ok_nxt;
    logic fail_nxt;
    logic skip_nxt;

    // States that run one bus cycle before they can move on.
    function automatic logic is_bus(input bevs_state_t s);
        is_bus = s inside {S_RD_CMD, S_RD_BYTE, S_PG_SETUP, S_PG_WRITE, S_PG_VCMD,
            S_PG_READ, S_ER_SETUP, S_ER_WRITE, S_EV_CMD, S_EV_READ, S_EXIT};
    endfunction

    // Length of each timed state, minus one; zero for the others.
    function automatic logic [23:0] dur(input bevs_state_t s);
        unique case (s)
            S_RAMP, S_VPP_DN: dur = 24'(VPP_CYC - 1);
            S_PG_PULSE: dur = 24'(PROG_CYC - 1);
            S_ER_PULSE: dur = 24'(ERASE_CYCLES - 1);
            S_PG_SETTLE, S_EV_SETTLE: dur = 24'(SETTLE_CYC - 1);
            default: dur = 24'h000000;
        endcase
    endfunction

    // Data byte each bus state writes; reads ignore it.
    function automatic logic [7:0] data_of(input bevs_state_t s);
        unique case (s)
            S_PG_SETUP: data_of = CMD_PROG_SETUP;
            S_PG_WRITE: data_of = DATA_ZERO;
            S_PG_VCMD: data_of = CMD_PROG_VFY;
            S_ER_SETUP, S_ER_WRITE: data_of = CMD_ERASE;
            S_EV_CMD: data_of = CMD_ERASE_VFY;
            S_EXIT: data_of = CMD_RESET;
            default: data_of = CMD_READ;
        endcase
    endfunction

    // Request decoding from the current state.
    wire logic st_bus = is_bus(state_r);
    wire logic req_go = st_bus && !pend_r;
    wire logic step = st_bus ? bus_done : (wait_r == 24'h000000);
    wire logic is_read = (state_r == S_RD_BYTE) || (state_r == S_PG_READ) || (state_r == S_EV_READ);
    wire logic at_last = (addr_r == LAST_ADDR);
    wire logic rd_erased = (bus_rdata == DATA_ERASED);
    wire logic rd_zero = (bus_rdata == DATA_ZERO);
    wire logic ecnt_limit = (erase_pulse_counter >= 10'(MAX_ERASE_PULSES));
    wire logic pcnt_limit = ((pcnt_r + 5'h01) >= 5'(MAX_PROG_PULSES));
    wire bevs_req_t req_nxt = '{wr: !is_read, addr: addr_r, data: data_of(state_r)};

    bevs_bus_cycle u_bus
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .req_valid(req_valid_r),
        .req(req_r),
        .dq_in(flash_dq_in),
        .pins(flash_pins),
        .done(bus_done),
        .rdata(bus_rdata)
    );

    // Sequencing of the whole erase flow, one step per bus cycle or timeout.
    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        pcnt_nxt = pcnt_r;
        ecnt_nxt = erase_pulse_counter;
        ok_nxt = erase_ok;
        fail_nxt = erase_fail;
        skip_nxt = erase_skipped;
        unique case (state_r)
            S_IDLE:
                if (start)
                begin
                    state_nxt = S_RAMP;
                    addr_nxt = '0;
                    ecnt_nxt = 10'h000;
                    ok_nxt = 1'b0;
                    fail_nxt = 1'b0;
                    skip_nxt = 1'b0;
                end
            S_RAMP:
                if (step)
                begin
                    state_nxt = S_RD_CMD;
                end
            S_RD_CMD:
                if (step)
                begin
                    state_nxt = S_RD_BYTE;
                end
            S_RD_BYTE:
                if (step)
                begin
                    if (!rd_erased)
                    begin
                        addr_nxt = '0;
                        pcnt_nxt = 5'h00;
                        state_nxt = S_PG_SETUP;
                    end
                    else if (at_last)
                    begin
                        skip_nxt = 1'b1;
                        state_nxt = S_EXIT;
                    end
                    else
                    begin
                        addr_nxt = addr_r + 1'b1;
                    end
                end
            S_PG_SETUP:
                if (step)
                begin
                    state_nxt = S_PG_WRITE;
                end
            S_PG_WRITE:
                if (step)
                begin
                    state_nxt = S_PG_PULSE;
                end
            S_PG_PULSE:
                if (step)
                begin
                    state_nxt = S_PG_VCMD;
                end
            S_PG_VCMD:
                if (step)
                begin
                    state_nxt = S_PG_SETTLE;
                end
            S_PG_SETTLE:
                if (step)
                begin
                    state_nxt = S_PG_READ;
                end
            S_PG_READ:
                if (step)
                begin
                    pcnt_nxt = pcnt_r + 5'h01;
                    if (rd_zero && at_last)
                    begin
                        addr_nxt = '0;
                        state_nxt = S_ER_SETUP;
                    end
                    else if (rd_zero)
                    begin
                        addr_nxt = addr_r + 1'b1;
                        pcnt_nxt = 5'h00;
                        state_nxt = S_PG_SETUP;
                    end
                    else if (pcnt_limit)
                    begin
                        fail_nxt = 1'b1;
                        state_nxt = S_EXIT;
                    end
                    else
                    begin
                        state_nxt = S_PG_SETUP;
                    end
                end
            S_ER_SETUP:
                if (step)
                begin
                    state_nxt = S_ER_WRITE;
                end
            S_ER_WRITE:
                if (step)
                begin
                    ecnt_nxt = erase_pulse_counter + 10'h001;
                    state_nxt = S_ER_PULSE;
                end
            S_ER_PULSE:
                if (step)
                begin
                    state_nxt = S_EV_CMD;
                end
            S_EV_CMD:
                if (step)
                begin
                    state_nxt = S_EV_SETTLE;
                end
            S_EV_SETTLE:
                if (step)
                begin
                    state_nxt = S_EV_READ;
                end
            S_EV_READ:
                if (step)
                begin
                    if (rd_erased && at_last)
                    begin
                        ok_nxt = 1'b1;
                        state_nxt = S_EXIT;
                    end
                    else if (rd_erased)
                    begin
                        addr_nxt = addr_r + 1'b1;
                        state_nxt = S_EV_CMD;
                    end
                    else if (ecnt_limit)
                    begin
                        fail_nxt = 1'b1;
                        state_nxt = S_EXIT;
                    end
                    else
                    begin
                        state_nxt = S_ER_SETUP;
                    end
                end
            S_EXIT:
                if (step)
                begin
                    state_nxt = S_VPP_DN;
                end
            S_VPP_DN:
                if (step)
                begin
                    state_nxt = S_IDLE;
                end
        endcase
    end

    // State and counters.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_r <= S_IDLE;
            addr_r <= '0;
            pcnt_r <= 5'h00;
            erase_pulse_counter <= 10'h000;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            pcnt_r <= pcnt_nxt;
            erase_pulse_counter <= ecnt_nxt;
        end
    end

    // Timeout counter, reloaded on every state change.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wait_r <= 24'h000000;
        end
        else if (state_nxt != state_r)
        begin
            wait_r <= dur(state_nxt);
        end
        else if (wait_r != 24'h000000)
        begin
            wait_r <= wait_r - 24'h000001;
        end
    end

    // One request per step of a bus state, so S_RD_BYTE issues one per address; pend blocks a repeat until done.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pend_r <= 1'b0;
            req_valid_r <= 1'b0;
            req_r <= '0;
        end
        else
        begin
            req_valid_r <= req_go;
            pend_r <= req_go ? 1'b1 : (bus_done ? 1'b0 : pend_r);
            if (req_go)
            begin
                req_r <= req_nxt;
            end
        end
    end

    // Supply switch: high voltage only while the flow runs, so the
    // flash sits read-only whenever the controller is idle.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            program_voltage_pin <= 1'b0;
            busy <= 1'b0;
            finished <= 1'b0;
        end
        else
        begin
            program_voltage_pin <= (state_nxt != S_IDLE) && (state_nxt != S_VPP_DN);
            busy <= (state_nxt != S_IDLE);
            finished <= (state_r == S_VPP_DN) && (state_nxt == S_IDLE);
        end
    end

    // Result flags hold until the next start; fail_addr keeps the address where the last failing flow stopped.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            erase_ok <= 1'b0;
            erase_fail <= 1'b0;
            erase_skipped <= 1'b0;
            fail_addr <= '0;
        end
        else
        begin
            erase_ok <= ok_nxt;
            erase_fail <= fail_nxt;
            erase_skipped <= skip_nxt;
            if (fail_nxt && !erase_fail)
            begin
                fail_addr <= addr_r;
            end
        end
    end
endmodule // bevs_erase_host

// File: dv/bevs_erase_host_sva.sv
// Checker for the erase host: watches the top module's ports only.
// Assumes one ref_clk domain and the synchronous active-low reset.
`timescale 1ns/100ps
module bevs_erase_host_chk
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire bevs_pkg::bevs_pins_t flash_pins,
    input wire logic program_voltage_pin,
    input wire logic busy,
    input wire logic finished,
    input wire logic erase_ok,
    input wire logic erase_fail,
    input wire logic erase_skipped,
    input wire logic [9:0] erase_pulse_counter
);
    import bevs_pkg::*;
    // All checks share the one clock and are quiet during reset.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    write_pins_a: assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n && flash_pins.dq_oe)
        else $error("strobe low without select, read disable or drive");
    no_clash_a: assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe)
        else $error("controller drives data while flash outputs");
    latch_stable_a: assert property (!flash_pins.we_n && $past(!flash_pins.we_n)
        |-> $stable(flash_pins.addr) && $stable(flash_pins.dq_out))
        else $error("address or data moved under a low strobe");
    cmd_hv_a: assert property ($fell(flash_pins.we_n) |-> program_voltage_pin)
        else $error("command written without high voltage");
    strobe_len_a: assert property ($fell(flash_pins.we_n) |-> (!flash_pins.we_n)[*8])
        else $error("write strobe too short");
    pulse_cap_a: assert property (erase_pulse_counter <= 10'(MAX_ERASE_PULSES))
        else $error("erase pulse count above limit");
    pulse_step_a: assert property (busy && $past(busy) && $changed(erase_pulse_counter)
        |-> erase_pulse_counter == $past(erase_pulse_counter) + 10'h001)
        else $error("erase pulse count jumped");
    fin_end_a: assert property (finished |-> !program_voltage_pin ##1 !finished)
        else $error("finish with high voltage or long finish pulse");
    skip_clean_a: assert property (erase_skipped |-> erase_pulse_counter == 10'h000 && !erase_fail)
        else $error("skipped flow applied erase pulses");
    busy_start_a: assert property (start && !busy |=> busy)
        else $error("start not taken");
endmodule // bevs_erase_host_chk

// File: dv/bevs_flash_model.sv
// Behavioural byte-wide flash with a command register, driven by pin edges.
// Assumes the bench presets mem and need through hierarchical access.
`timescale 1ns/100ps
module bevs_flash_model
#(
    parameter int DEPTH = 8
)
(
    input wire bevs_pkg::bevs_pins_t pins,
    input wire logic vpp,
    output logic [7:0] dq
);
    import bevs_pkg::*;
    logic [7:0] mem [DEPTH];
    int need [DEPTH];
    int hits [DEPTH];
    int pulses = 0;
    int verifies = 0;
    int misuse = 0;
    int resets = 0;
    logic [7:0] cmd_r = CMD_READ;
    logic [ADDR_W-1:0] lat_r = '0;
    logic [7:0] rd_byte;
    wire vfy_mode = (cmd_r == CMD_ERASE_VFY) || (cmd_r == CMD_PROG_VFY);

    // Verify reads use the latched address; a margin read shows FFh only when erased.
    // Undriven pins show the inverted byte, so a sampling slip cannot pass by luck.
    assign rd_byte = vfy_mode ? mem[int'(lat_r) % DEPTH] : mem[int'(pins.addr) % DEPTH];
    assign dq = (!pins.ce_n && !pins.oe_n) ? rd_byte : ~rd_byte;

    // Address is taken at whichever of strobe and select falls last.
    always @(negedge pins.we_n or negedge pins.ce_n)
        if (!pins.we_n && !pins.ce_n)
            lat_r = pins.addr;

    // Losing high voltage drops the register back to read mode.
    always @(negedge vpp)
        cmd_r = CMD_READ;

    // Commands are taken at the strobe's rising edge with select low and reads off.
    always @(posedge pins.we_n)
        if (!pins.ce_n && pins.oe_n && vpp)
        begin
            if (cmd_r == CMD_PROG_SETUP)
            begin
                mem[int'(lat_r) % DEPTH] &= pins.dq_out;
                cmd_r = CMD_READ;
            end
            else if (cmd_r == CMD_ERASE && pins.dq_out == CMD_ERASE)
            begin
                // Each pulse has one fixed effect however long the host waits: the model keeps no timer.
                pulses++;
                for (int i = 0; i < DEPTH; i++)
                begin
                    if (mem[i] != DATA_ZERO && hits[i] == 0)
                        misuse++;
                    hits[i]++;
                    if (hits[i] >= need[i])
                        mem[i] = DATA_ERASED;
                end
                cmd_r = CMD_READ;
            end
            else
            begin
                if (pins.dq_out == CMD_ERASE_VFY)
                    verifies++;
                // The reset code is counted so that a flow ending without it shows up.
                if (pins.dq_out == CMD_RESET)
                    resets++;
                cmd_r = (pins.dq_out == CMD_RESET) ? CMD_READ : pins.dq_out;
            end
        end
endmodule // bevs_flash_model

// File: dv/tb.sv
// Self-checking bench for the erase host against the flash model.
// Assumes a 200 MHz ref_clk and a short erase pulse parameter for speed.
`timescale 1ns/100ps
module tb;
    import bevs_pkg::*;
    logic ref_clk;
    logic reset_n;
    logic start;
    bevs_pins_t pins;
    logic vpp, busy, finished, ok, fail, skipped;
    logic [9:0] cnt;
    logic [ADDR_W-1:0] faddr;
    logic [7:0] dq;
    int num_errors = 0;
    int samples_checked = 0;

    bevs_erase_host #(.ERASE_CYCLES(50), .LAST_ADDR(17'h00007)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .start(start), .flash_dq_in(dq), .flash_pins(pins), .program_voltage_pin(vpp), .busy(busy),
        .finished(finished), .erase_ok(ok), .erase_fail(fail), .erase_skipped(skipped),
        .erase_pulse_counter(cnt), .fail_addr(faddr));
    bevs_flash_model #(.DEPTH(8)) flash (.pins(pins), .vpp(vpp), .dq(dq));

    // Clock at 5 ns period.
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("TB: checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Presets array contents; byte 5 needs slow pulses before it reads erased.
    task automatic fill(input logic [7:0] v, input int slow);
        for (int i = 0; i < 8; i++)
        begin
            flash.mem[i] = v;
            flash.need[i] = (i == 5) ? slow : 1;
            flash.hits[i] = 0;
        end
        flash.pulses = 0;
        flash.verifies = 0;
        flash.misuse = 0;
        flash.resets = 0;
    endtask

    // One flow; a second start pulse mid-run must be ignored.
    task automatic run_flow();
        int n;
        n = 0;
        @(posedge ref_clk) start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        repeat (5) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        while (finished !== 1'b1 && n < 100000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 100000)
        begin
            num_errors++;
            $display("BAD t=%0t flow hang %h %h", $time, n, 100000);
            close_out();
        end
        repeat (3) @(posedge ref_clk);
        #1;
        check(32'(busy), 32'h0);
        check(32'(vpp), 32'h0);
    endtask

    // Blank array: no erase at all.
    task automatic test_blank();
        fill(8'hff, 1);
        run_flow();
        check(32'(skipped), 32'h1);
        check(32'(cnt), 32'h0);
        check(flash.pulses, 32'h0);
        check(flash.resets, 32'h1);
        $display("test blank done");
    endtask

    // Programmed array with one slow byte: resume at the failing address.
    task automatic test_resume();
        fill(8'h3c, 3);
        run_flow();
        check(32'(ok), 32'h1);
        check(32'(fail), 32'h0);
        check(32'(skipped), 32'h0);
        check(32'(cnt), 32'h3);
        check(flash.pulses, 32'h3);
        check(flash.misuse, 32'h0);
        check(flash.verifies, 32'ha);
        check(32'(flash.cmd_r), 32'(CMD_READ));
        check(flash.resets, 32'h1);
        check(32'(faddr), 32'h0);
        for (int i = 0; i < 8; i++)
            check(32'(flash.mem[i]), 32'hff);
        $display("test resume done");
    endtask

    // Reset in mid-flow returns pins and status to rest.
    task automatic test_reset();
        fill(8'h3c, 1);
        @(posedge ref_clk) start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        repeat (100) @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(32'(pins), {3'h0, 17'h0, 8'h0, 4'h7});
        check(32'(vpp), 32'h0);
        check(32'({busy, ok, fail, skipped, cnt, finished, faddr}), 32'h0);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        // With start low the controller must stay at rest after the release.
        check(32'({busy, vpp, finished}), 32'h0);
        check(32'(pins), {3'h0, 17'h0, 8'h0, 4'h7});
        $display("test reset done");
    endtask

    // Main sequence.
    initial
    begin
        reset_n = 1'b0;
        start = 1'b0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        test_blank();
        test_resume();
        test_reset();
        close_out();
    end
endmodule // tb

bind bevs_erase_host bevs_erase_host_chk chk (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
    .flash_pins(flash_pins), .program_voltage_pin(program_voltage_pin), .busy(busy), .finished(finished),
    .erase_ok(erase_ok), .erase_fail(erase_fail), .erase_skipped(erase_skipped),
    .erase_pulse_counter(erase_pulse_counter));
